// ### rtl/ffc_cfg.svh
// Offsets, field masks, reset values for the fault flag and control block.
// Assumes a 16-bit register address from the serial port decoder.
`ifndef FFC_CFG_SVH
`define FFC_CFG_SVH

`define FFC_OFS_DEV_FLAGS 16'h0011
`define FFC_OFS_IN_FLAGS 16'h0012
`define FFC_OFS_PLL_FLAGS 16'h0013
`define FFC_OFS_CAL_FLAGS 16'h0014
`define FFC_OFS_DEV_MASKS 16'h0017
`define FFC_OFS_IN_MASKS 16'h0018
`define FFC_OFS_PLL_MASKS 16'h0019
`define FFC_OFS_CAL_MASKS 16'h001A
`define FFC_OFS_SOFT_RST 16'h001C
`define FFC_OFS_FSTEP 16'h001D
`define FFC_OFS_PWR_CTRL 16'h001E

`define FFC_DEV_BITS 8'h2F
`define FFC_IN_BITS 8'hFF
`define FFC_PLL_BITS 8'h33
`define FFC_CAL_BITS 8'h30

`define FFC_BIT_RST_ALL 0
`define FFC_BIT_RST_A 1
`define FFC_BIT_RST_B 2
`define FFC_BIT_STEP_UP 0
`define FFC_BIT_STEP_DN 1
`define FFC_BIT_PDN 0
`define FFC_BIT_HARD 1
`define FFC_BIT_SYNC 2

`define FFC_FLAG_RESET 8'h00
`define FFC_MASK_RESET 8'h00
`define FFC_ZERO 8'h00

`endif

// ### rtl/ffc_pkg.sv
// Types shared by the fault flag and control block.
// Assumes nothing beyond the configuration header.
`default_nettype none
package ffc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ffc_req_t;

    typedef struct packed {
        logic rvalid;
        logic [7:0] rdata;
    } ffc_rsp_t;

    typedef struct packed {
        logic device_restart;
        logic params_apply;
        logic pll_a_restart;
        logic pll_b_restart;
        logic freq_step_up;
        logic freq_step_down;
        logic low_current_state;
        logic relock_request;
        logic nvm_reload;
        logic divider_realign;
    } ffc_ctl_t;
endpackage
`default_nettype wire

// ### rtl/ffc_top.sv
// Sticky fault flags, interrupt masks and self-clearing control strobes.
// Assumes the serial port decoder presents one-cycle rd/wr requests and that
// the live status bits come from detectors in the sys_clk domain.
`include "ffc_cfg.svh"
`default_nettype none

module ffc_top
    import ffc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire ffc_req_t host_req,
    input wire logic [7:0] dev_live,
    input wire logic [7:0] in_live,
    input wire logic [7:0] pll_live,
    input wire logic [7:0] cal_live,
    input wire logic [3:0] freq_step_block_bits,
    output var ffc_rsp_t host_rsp,
    output var ffc_ctl_t ctl_out,
    output var logic irq_out_n
);

    // Set beats clear: the live term is ORed in after the clear.
    function automatic logic [7:0] sticky_next(
        input logic [7:0] flag,
        input logic [7:0] live,
        input logic hit,
        input logic [7:0] wdata,
        input logic [7:0] valid
    );
        logic [7:0] clr;
        clr = hit ? (~wdata & ~live) : `FFC_ZERO;
        sticky_next = ((flag & ~clr) | live) & valid;
    endfunction

    function automatic logic wr_hit(input ffc_req_t r, input logic [15:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    function automatic logic unmasked(
        input logic [7:0] flag,
        input logic [7:0] mask
    );
        unmasked = |(flag & ~mask);
    endfunction

    logic [7:0] dev_flags_reg, dev_flags_next;
    logic [7:0] in_flags_reg, in_flags_next;
    logic [7:0] pll_flags_reg, pll_flags_next;
    logic [7:0] cal_flags_reg, cal_flags_next;
    logic [7:0] dev_mask_reg, dev_mask_next;
    logic [7:0] in_mask_reg, in_mask_next;
    logic [7:0] pll_mask_reg, pll_mask_next;
    logic [7:0] cal_mask_reg, cal_mask_next;
    logic irq_n_reg, irq_n_next;

    // Flags and masks
    always_comb begin
        dev_flags_next = sticky_next(dev_flags_reg, dev_live & `FFC_DEV_BITS,
            wr_hit(host_req, `FFC_OFS_DEV_FLAGS), host_req.wdata,
            `FFC_DEV_BITS);
        in_flags_next = sticky_next(in_flags_reg, in_live,
            wr_hit(host_req, `FFC_OFS_IN_FLAGS), host_req.wdata,
            `FFC_IN_BITS);
        pll_flags_next = sticky_next(pll_flags_reg, pll_live & `FFC_PLL_BITS,
            wr_hit(host_req, `FFC_OFS_PLL_FLAGS), host_req.wdata,
            `FFC_PLL_BITS);
        cal_flags_next = sticky_next(cal_flags_reg, cal_live & `FFC_CAL_BITS,
            wr_hit(host_req, `FFC_OFS_CAL_FLAGS), host_req.wdata,
            `FFC_CAL_BITS);
        dev_mask_next = wr_hit(host_req, `FFC_OFS_DEV_MASKS) ?
            (host_req.wdata & `FFC_DEV_BITS) : dev_mask_reg;
        in_mask_next = wr_hit(host_req, `FFC_OFS_IN_MASKS) ?
            host_req.wdata : in_mask_reg;
        pll_mask_next = wr_hit(host_req, `FFC_OFS_PLL_MASKS) ?
            (host_req.wdata & `FFC_PLL_BITS) : pll_mask_reg;
        cal_mask_next = wr_hit(host_req, `FFC_OFS_CAL_MASKS) ?
            (host_req.wdata & `FFC_CAL_BITS) : cal_mask_reg;
        // Follows the registered flags, so the pin lags a flag by one cycle
        irq_n_next = !(unmasked(dev_flags_reg, dev_mask_reg) ||
            unmasked(in_flags_reg, in_mask_reg) ||
            unmasked(pll_flags_reg, pll_mask_reg) ||
            unmasked(cal_flags_reg, cal_mask_reg));
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dev_flags_reg <= `FFC_FLAG_RESET;
            in_flags_reg <= `FFC_FLAG_RESET;
            pll_flags_reg <= `FFC_FLAG_RESET;
            cal_flags_reg <= `FFC_FLAG_RESET;
            dev_mask_reg <= `FFC_MASK_RESET;
            in_mask_reg <= `FFC_MASK_RESET;
            pll_mask_reg <= `FFC_MASK_RESET;
            cal_mask_reg <= `FFC_MASK_RESET;
            irq_n_reg <= 1'b1;
        end else begin
            dev_flags_reg <= dev_flags_next;
            in_flags_reg <= in_flags_next;
            pll_flags_reg <= pll_flags_next;
            cal_flags_reg <= cal_flags_next;
            dev_mask_reg <= dev_mask_next;
            in_mask_reg <= in_mask_next;
            pll_mask_reg <= pll_mask_next;
            cal_mask_reg <= cal_mask_next;
            irq_n_reg <= irq_n_next;
        end
    end

    assign irq_out_n = irq_n_reg;

    // Control strobes
    ffc_ctl_t ctl_reg, ctl_next;
    logic rst_hit, step_hit, pwr_hit, step_open;

    always_comb begin
        rst_hit = wr_hit(host_req, `FFC_OFS_SOFT_RST);
        step_hit = wr_hit(host_req, `FFC_OFS_FSTEP);
        pwr_hit = wr_hit(host_req, `FFC_OFS_PWR_CTRL);
        step_open = (freq_step_block_bits == 4'h0);
        // Strobes are single-cycle; only low_current_state stays stored, so every strobe 1 retriggers
        ctl_next = '0;
        ctl_next.device_restart = rst_hit &&
            host_req.wdata[`FFC_BIT_RST_ALL];
        ctl_next.params_apply = ctl_next.device_restart;
        ctl_next.pll_a_restart = rst_hit &&
            host_req.wdata[`FFC_BIT_RST_A];
        ctl_next.pll_b_restart = rst_hit &&
            host_req.wdata[`FFC_BIT_RST_B];
        ctl_next.freq_step_up = step_hit && step_open &&
            host_req.wdata[`FFC_BIT_STEP_UP];
        ctl_next.freq_step_down = step_hit && step_open &&
            host_req.wdata[`FFC_BIT_STEP_DN];
        ctl_next.low_current_state = pwr_hit ?
            host_req.wdata[`FFC_BIT_PDN] : ctl_reg.low_current_state;
        ctl_next.relock_request = ctl_reg.low_current_state &&
            !ctl_next.low_current_state;
        ctl_next.nvm_reload = pwr_hit &&
            host_req.wdata[`FFC_BIT_HARD];
        ctl_next.divider_realign = pwr_hit &&
            host_req.wdata[`FFC_BIT_SYNC];
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctl_reg <= '0;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign ctl_out = ctl_reg;

    // Read port; write-only strobe bits read back as zero
    ffc_rsp_t rsp_reg, rsp_next;

    always_comb begin
        rsp_next.rvalid = host_req.rd;
        unique case (host_req.addr)
            `FFC_OFS_DEV_FLAGS: rsp_next.rdata = dev_flags_reg;
            `FFC_OFS_IN_FLAGS: rsp_next.rdata = in_flags_reg;
            `FFC_OFS_PLL_FLAGS: rsp_next.rdata = pll_flags_reg;
            `FFC_OFS_CAL_FLAGS: rsp_next.rdata = cal_flags_reg;
            `FFC_OFS_DEV_MASKS: rsp_next.rdata = dev_mask_reg;
            `FFC_OFS_IN_MASKS: rsp_next.rdata = in_mask_reg;
            `FFC_OFS_PLL_MASKS: rsp_next.rdata = pll_mask_reg;
            `FFC_OFS_CAL_MASKS: rsp_next.rdata = cal_mask_reg;
            `FFC_OFS_PWR_CTRL: rsp_next.rdata = {7'h00,
                ctl_reg.low_current_state};
            default: rsp_next.rdata = `FFC_ZERO;
        endcase
        if (!host_req.rd) begin
            rsp_next.rdata = rsp_reg.rdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign host_rsp = rsp_reg;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_in_set;
        in_live[0] |=> in_flags_reg[0];
    endproperty
    a_in_set: assert property (p_in_set)
        else $error("input flag not set by live loss");

    property p_sticky_hold;
        in_flags_reg[4] && !wr_hit(host_req, `FFC_OFS_IN_FLAGS)
            |=> in_flags_reg[4];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("sticky flag dropped without a write");

    property p_clear_blocked;
        wr_hit(host_req, `FFC_OFS_PLL_FLAGS) && !host_req.wdata[0] &&
            pll_live[0] |=> pll_flags_reg[0];
    endproperty
    a_clear_blocked: assert property (p_clear_blocked)
        else $error("flag cleared while condition live");

    property p_clear_ok;
        wr_hit(host_req, `FFC_OFS_CAL_FLAGS) && !host_req.wdata[5] &&
            !cal_live[5] |=> !cal_flags_reg[5];
    endproperty
    a_clear_ok: assert property (p_clear_ok)
        else $error("calibration flag not cleared");

    property p_dev_set;
        dev_live[5] |=> dev_flags_reg[5];
    endproperty
    a_dev_set: assert property (p_dev_set)
        else $error("bus timeout flag not set");

    sequence s_flag_unmasked;
        pll_flags_reg[4] && !pll_mask_reg[4];
    endsequence
    property p_irq;
        s_flag_unmasked |=> !irq_out_n;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised for unmasked flag");

    property p_irq_quiet;
        !unmasked(dev_flags_reg, dev_mask_reg) &&
            !unmasked(in_flags_reg, in_mask_reg) &&
            !unmasked(pll_flags_reg, pll_mask_reg) &&
            !unmasked(cal_flags_reg, cal_mask_reg) |=> irq_out_n;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt raised with all flags masked");

    sequence s_soft_all;
        rst_hit && host_req.wdata[0];
    endsequence
    property p_soft_all;
        s_soft_all |=> ctl_out.device_restart && ctl_out.params_apply
            ##1 (!ctl_out.device_restart || $past(rst_hit));
    endproperty
    a_soft_all: assert property (p_soft_all)
        else $error("whole reset strobe wrong");

    property p_pll_rst;
        rst_hit && host_req.wdata[`FFC_BIT_RST_A] &&
            !host_req.wdata[`FFC_BIT_RST_ALL]
            |=> ctl_out.pll_a_restart && !ctl_out.params_apply;
    endproperty
    a_pll_rst: assert property (p_pll_rst)
        else $error("PLL restart applied parameters");

    property p_step_blocked;
        step_hit && (freq_step_block_bits != 4'h0)
            |=> !ctl_out.freq_step_up && !ctl_out.freq_step_down;
    endproperty
    a_step_blocked: assert property (p_step_blocked)
        else $error("frequency step while blocked");

    property p_relock;
        $fell(ctl_out.low_current_state) |-> ctl_out.relock_request;
    endproperty
    a_relock: assert property (p_relock)
        else $error("no relock on power-down exit");

    property p_hard_sync;
        pwr_hit && host_req.wdata[1] && host_req.wdata[2]
            |=> ctl_out.nvm_reload && ctl_out.divider_realign;
    endproperty
    a_hard_sync: assert property (p_hard_sync)
        else $error("hard reset or realign strobe missing");

    sequence s_step_up_req;
        step_hit && step_open && host_req.wdata[`FFC_BIT_STEP_UP];
    endsequence
    property p_step_up;
        s_step_up_req |=> ctl_out.freq_step_up;
    endproperty
    a_step_up: assert property (p_step_up)
        else $error("step up strobe missing");

    property p_step_down;
        step_hit && step_open && host_req.wdata[`FFC_BIT_STEP_DN]
            |=> ctl_out.freq_step_down;
    endproperty
    a_step_down: assert property (p_step_down)
        else $error("step down strobe missing");

    property p_pll_b_rst;
        rst_hit && host_req.wdata[`FFC_BIT_RST_B] &&
            !host_req.wdata[`FFC_BIT_RST_ALL]
            |=> ctl_out.pll_b_restart && !ctl_out.params_apply;
    endproperty
    a_pll_b_rst: assert property (p_pll_b_rst)
        else $error("PLL B restart wrong");

    // An nvm_reload or divider_realign strobe with no new write behind it must not linger
    property p_strobe_clear;
        (ctl_out.nvm_reload || ctl_out.divider_realign) && !pwr_hit
            |=> !ctl_out.nvm_reload && !ctl_out.divider_realign;
    endproperty
    a_strobe_clear: assert property (p_strobe_clear)
        else $error("control strobe did not clear");

    property p_pdn_hold;
        !pwr_hit |=> $stable(ctl_out.low_current_state);
    endproperty
    a_pdn_hold: assert property (p_pdn_hold)
        else $error("power-down level changed without a write");

    property p_strobe_read;
        host_req.rd && (host_req.addr == `FFC_OFS_SOFT_RST ||
            host_req.addr == `FFC_OFS_FSTEP)
            |=> host_rsp.rvalid && host_rsp.rdata == `FFC_ZERO;
    endproperty
    a_strobe_read: assert property (p_strobe_read)
        else $error("strobe register read back nonzero");

    property p_irq_in;
        in_flags_reg[1] && !in_mask_reg[1] |=> !irq_out_n;
    endproperty
    a_irq_in: assert property (p_irq_in)
        else $error("input flag did not raise interrupt");

endmodule
`default_nettype wire

// ### sim/ffc_host_model.sv
// Host controller model on the serial control port of the flag block.
// Assumes a free running sys_clk and a bench that calls its tasks in turn.
`default_nettype none
module ffc_host_model
    import ffc_pkg::*;
(
    input wire logic sys_clk,
    input wire ffc_rsp_t host_rsp,
    output var ffc_req_t host_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial host_req = '{wr: 1'b0, rd: 1'b0, addr: 16'hFFFF, wdata: 8'hFF};

    // Released fields flip so a stale address or byte is never reused
    task automatic release_bus();
        host_req.wr = 1'b0;
        host_req.rd = 1'b0;
        host_req.addr = ~host_req.addr;
        host_req.wdata = ~host_req.wdata;
    endtask

    // Clears are issued once the live cause is gone, except where the
    // bench means to be refused
    // Bandwidth update strobes sit outside this block, none issued
    task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        host_req.wr = 1'b1;
        host_req.addr = a;
        host_req.wdata = d;
        @(posedge sys_clk);
        #2;
        release_bus();
    endtask

    // Answer is registered, so it is taken one edge after the request
    task automatic read_reg(input logic [15:0] a, output logic [7:0] d,
                            output logic v);
        @(posedge sys_clk);
        #2;
        host_req.rd = 1'b1;
        host_req.addr = a;
        @(posedge sys_clk);
        #2;
        release_bus();
        v = host_rsp.rvalid;
        d = host_rsp.rdata;
    endtask
endmodule
`default_nettype wire

// ### sim/test_fault_flag_irq_and_reset_ctrl.sv
// Self-checking bench for the sticky flag, mask and strobe block.
// Assumes ffc_top, ffc_pkg and the host model are compiled before it.
`default_nettype none
module test_fault_flag_irq_and_reset_ctrl
    import ffc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [1:0] sel;
        logic [15:0] flag_a;
        logic [15:0] mask_a;
        logic [7:0] bits;
    } ffc_flag_row_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic [3:0] block;
        logic [9:0] exp;
    } ffc_strobe_row_t;

    localparam ffc_flag_row_t FLAG_ROWS [4] = '{
        '{2'h0, 16'h0011, 16'h0017, 8'h2F},
        '{2'h1, 16'h0012, 16'h0018, 8'hFF},
        '{2'h2, 16'h0013, 16'h0019, 8'h33},
        '{2'h3, 16'h0014, 16'h001A, 8'h30}};
    // Power-down rows last: the level must be 0 for the other rows
    localparam ffc_strobe_row_t STROBE_ROWS [11] = '{
        '{16'h001C, 8'h01, 4'h0, 10'h300},
        '{16'h001C, 8'h02, 4'h0, 10'h080},
        '{16'h001C, 8'h04, 4'h0, 10'h040},
        '{16'h001D, 8'h01, 4'h0, 10'h020},
        '{16'h001D, 8'h02, 4'h0, 10'h010},
        '{16'h001D, 8'h01, 4'h1, 10'h000},
        '{16'h001D, 8'h02, 4'h8, 10'h000},
        '{16'h001E, 8'h02, 4'h0, 10'h002},
        '{16'h001E, 8'h04, 4'h0, 10'h001},
        '{16'h001E, 8'h01, 4'h0, 10'h008},
        '{16'h001E, 8'h00, 4'h0, 10'h004}};

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] live_v [4] = '{default: 8'h00};
    logic [3:0] block = 4'h0;
    ffc_req_t host_req;
    ffc_rsp_t host_rsp;
    ffc_ctl_t ctl_out;
    logic irq_out_n;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #25 sys_clk = ~sys_clk;

    ffc_top i_dut (
        .sys_clk(sys_clk),
        .reset(reset),
        .host_req(host_req),
        .dev_live(live_v[0]),
        .in_live(live_v[1]),
        .pll_live(live_v[2]),
        .cal_live(live_v[3]),
        .freq_step_block_bits(block),
        .host_rsp(host_rsp),
        .ctl_out(ctl_out),
        .irq_out_n(irq_out_n)
    );

    ffc_host_model i_host (
        .sys_clk(sys_clk),
        .host_rsp(host_rsp),
        .host_req(host_req)
    );

    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check1(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic check8(input string what, input logic [7:0] e,
                          input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_ctl(input logic [9:0] e, input ffc_ctl_t g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error ctl_out expected %h seen %h", e, g);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a,
                          input logic [7:0] e);
        logic [7:0] d;
        logic v;
        i_host.read_reg(a, d, v);
        check1("rvalid", 1'b1, v);
        check8(what, e, d);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("Error timeout expected done seen running");
            summarize();
        end
    end

    initial begin
        idle(12);
        check1("irq in reset", 1'b1, irq_out_n);
        check_ctl(10'h000, ctl_out);
        reset = 1'b0;
        for (int a = 16'h0011; a <= 16'h001F; a++) begin
            rd_chk("reset value", a[15:0], 8'h00);
        end
        for (int r = 0; r < 4; r++) begin
            i_host.write_reg(FLAG_ROWS[r].mask_a, 8'hFF);
            rd_chk("mask", FLAG_ROWS[r].mask_a, FLAG_ROWS[r].bits);
            live_v[FLAG_ROWS[r].sel] = 8'hFF;
            idle(1);
            live_v[FLAG_ROWS[r].sel] = 8'h00;
            idle(1);
            rd_chk("flag", FLAG_ROWS[r].flag_a,
                FLAG_ROWS[r].bits);
            check1("irq masked", 1'b1, irq_out_n);
            i_host.write_reg(FLAG_ROWS[r].mask_a, 8'h00);
            idle(2);
            check1("irq unmasked", 1'b0, irq_out_n);
            i_host.write_reg(FLAG_ROWS[r].flag_a, 8'h00);
            rd_chk("flag cleared", FLAG_ROWS[r].flag_a, 8'h00);
            check1("irq idle", 1'b1, irq_out_n);
        end
        // A clear while the cause persists must be lost
        live_v[1] = 8'h04;
        idle(2);
        i_host.write_reg(16'h0012, 8'h00);
        rd_chk("flag live", 16'h0012, 8'h04);
        live_v[1] = 8'h00;
        i_host.write_reg(16'h0012, 8'h00);
        i_host.write_reg(16'h0012, 8'hFF);
        rd_chk("flag no set", 16'h0012, 8'h00);
        // Second pass proves each strobe cleared itself and fires again
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 11; r++) begin
                block = STROBE_ROWS[r].block;
                i_host.write_reg(STROBE_ROWS[r].addr, STROBE_ROWS[r].data);
                check_ctl(STROBE_ROWS[r].exp,
                    ctl_out);
                idle(1);
                check_ctl(STROBE_ROWS[r].exp & 10'h008, ctl_out);
            end
        end
        i_host.write_reg(16'h001E, 8'h01);
        rd_chk("pwr ctrl", 16'h001E, 8'h01);
        rd_chk("soft rst", 16'h001C, 8'h00);
        rd_chk("step", 16'h001D, 8'h00);
        i_host.write_reg(16'h001E, 8'h00);
        live_v[3] = 8'h30;
        idle(2);
        live_v[3] = 8'h00;
        idle(1);
        check1("irq cal", 1'b0, irq_out_n);
        reset = 1'b1;
        idle(2);
        check1("irq reset", 1'b1, irq_out_n);
        reset = 1'b0;
        rd_chk("after reset", 16'h0014, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
